// File: sfss_defs.svh
`ifndef SFSS_DEFS_SVH
`define SFSS_DEFS_SVH

// ****************************************
// array geometry
// ****************************************
`define SFSS_ADDR_W      15
`define SFSS_DEPTH       32768

// ****************************************
// serial opcodes
// ****************************************
`define SFSS_OP_WRSR     8'h01
`define SFSS_OP_WRITE    8'h02
`define SFSS_OP_READ     8'h03
`define SFSS_OP_WRDI     8'h04
`define SFSS_OP_RDSR     8'h05
`define SFSS_OP_WREN     8'h06
`define SFSS_OP_RDID     8'h9f

// ****************************************
// serial status byte layout
// ****************************************
`define SFSS_SR_PEN_BIT  7
`define SFSS_SR_BP_MSB   3
`define SFSS_SR_BP_LSB   2
`define SFSS_SR_WEL_BIT  1
`define SFSS_SR_WR_MASK  8'h8c
`define SFSS_SR_RESET    8'h00

// ****************************************
// apb register map
// ****************************************
`define SFSS_REG_CTRL    12'h000
`define SFSS_REG_STATUS  12'h004
`define SFSS_REG_ADDR    12'h008
`define SFSS_CTRL_EN_BIT 0
`define SFSS_CTRL_RESET  1'b1
`define SFSS_STS_MODE    8
`define SFSS_STS_ST_LSB  9
`define SFSS_STS_SEL     12

// ****************************************
// pin synchroniser
// ****************************************
`define SFSS_PINS_RESET  5'h13

`endif

// File: sfss_pkg.sv
package sfss_pkg;

    // ****************************************
    // command sequencer states, gray along the usual path
    // ****************************************
    typedef enum logic [2:0]
    {
        SFSS_ST_IDLE   = 3'h0,
        SFSS_ST_OPC    = 3'h1,
        SFSS_ST_ADDR   = 3'h3,
        SFSS_ST_XFER   = 3'h2,
        SFSS_ST_IGNORE = 3'h6
    } sfss_state_t;

    // ****************************************
    // serial pins travelling together through the synchroniser
    // ****************************************
    typedef struct packed
    {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        logic hold_n;
    } sfss_pins_t;

endpackage

// File: sfss_sync.sv
`timescale 1ns/1ps

module sfss_sync
#(
    parameter int              WIDTH     = 5,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    initial
    begin
        if (WIDTH < 1)
            $error("sfss_sync needs at least one bit");
    end

    // first stage feeds only the second stage
    always_comb
    begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // reset to the idle pin levels so nothing looks like an edge
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule

// File: sfss_spi_slave.sv
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "sfss_defs.svh"

// Notes on behaviour
// RQ1 - serial input bits are taken only on rising serial clock edges
// RQ2 - serial clock may run slow or stop anywhere; state is kept
// RQ3 - deselected: standby, other inputs ignored, serial output high impedance
// RQ4 - serial clock is used internally only while select is low
// RQ5 - master drops select before each opcode; one opcode per selection
// RQ6 - serial output changes only on falling serial clock edges
// RQ7 - output driven only for read data; released while hold is low
// RQ8 - protect pin low with pin-enable bit set blocks status writes
// RQ9 - hold low freezes the operation and ignores clock and select
// RQ10 - master changes hold only while serial clock is low
// RQ11 - modes 0 and 3 are both served
// RQ12 - each byte is written to the array on its eighth bit
// RQ13 - array holds 32768 byte locations
// RQ14 - block protection of top quarter, top half or whole array
// RQ15 - write-disable command clears write permission
// RQ16 - read-only identification bytes can be read out
// RQ17 - first byte after select falls is the opcode
// RQ18 - two address bytes, msb first, top bit ignored
// RQ19 - unknown opcode: ignore everything until next select fall
// RQ20 - clock low at select fall means mode 0, high means mode 3
module sfss_spi_slave
#(
    parameter int          ADDR_W    = `SFSS_ADDR_W,
    parameter int          DEPTH     = `SFSS_DEPTH,
    parameter logic [31:0] DEVICE_ID = 32'h5a_a5_3c_c3 // arbitrary value
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        si,
    input  wire logic        wp_n,
    input  wire logic        hold_n,
    output logic             so_o,
    output logic             so_oe
);

    // ****************************************
    // elaboration checks
    // ****************************************
    initial
    begin
        if (ADDR_W < 10 || ADDR_W > 16 || DEPTH != (1 << ADDR_W))
            $error("sfss_spi_slave: address width and depth do not match");
    end

    // ****************************************
    // pin synchronisation and edge finding
    // ****************************************
    sfss_pkg::sfss_pins_t pins_raw;
    sfss_pkg::sfss_pins_t pin;
    logic                 sck_p_q;
    logic                 csn_q;
    logic                 csn_d;
    logic                 ctrl_en_q;
    logic                 ctrl_en_d;
    logic                 cs_eff;
    logic                 cs_fall;
    logic                 cs_rise;
    logic                 sck_rise;
    logic                 sck_fall;

    assign pins_raw = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n, hold_n: hold_n};

    sfss_sync
    #(
        .WIDTH     ($bits(sfss_pkg::sfss_pins_t)),
        .RESET_VAL (`SFSS_PINS_RESET)
    )
    u_sync
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .async_i (pins_raw),
        .sync_o  (pin)
    );

    // select edges only count while hold is high; disabled block looks deselected
    always_comb
    begin
        cs_eff   = pin.cs_n | ~ctrl_en_q;
        csn_d    = pin.hold_n ? cs_eff : csn_q;                  // [RQ9]
        cs_fall  = pin.hold_n & csn_q & ~cs_eff;
        cs_rise  = pin.hold_n & ~csn_q & cs_eff;
        sck_rise = pin.hold_n & ~csn_q & pin.sck & ~sck_p_q;    // [RQ1] [RQ4] [RQ9]
        sck_fall = pin.hold_n & ~csn_q & ~pin.sck & sck_p_q;    // [RQ6]
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic is_read_op(input logic [7:0] op);
        is_read_op = (op == `SFSS_OP_READ) || (op == `SFSS_OP_RDSR) ||
                     (op == `SFSS_OP_RDID);
    endfunction

    // top quarter, top half or all of the array
    function automatic logic is_protected(input logic [ADDR_W-1:0] a,
                                          input logic [1:0]        bp);
        case (bp)
            2'h1:    is_protected = &a[ADDR_W-1 -: 2];
            2'h2:    is_protected = a[ADDR_W-1];
            2'h3:    is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] id_byte(input logic [1:0] idx);
        id_byte = DEVICE_ID[8*(3-idx) +: 8];
    endfunction

    // ****************************************
    // command sequencer
    // ****************************************
    sfss_pkg::sfss_state_t state_q;
    sfss_pkg::sfss_state_t state_d;
    logic [2:0]            cnt_q;
    logic [2:0]            cnt_d;
    logic [7:0]            sh_q;
    logic [7:0]            sh_d;
    logic [7:0]            op_q;
    logic [7:0]            op_d;
    logic [ADDR_W-1:0]     addr_q;
    logic [ADDR_W-1:0]     addr_d;
    logic [ADDR_W-1:0]     addr_inc;
    logic [7:0]            tx_q;
    logic [7:0]            tx_d;
    logic [7:0]            sr_q;
    logic [7:0]            sr_d;
    logic [7:0]            sr_view;
    logic                  wel_q;
    logic                  wel_d;
    logic                  mode3_q;
    logic                  mode3_d;
    logic                  nab_q;
    logic                  nab_d;
    logic                  wr_ok_q;
    logic                  wr_ok_d;
    logic                  so_q;
    logic                  so_d;
    logic                  so_oe_q;
    logic                  so_oe_d;
    logic                  mem_we;
    logic [7:0]            rx_byte;
    logic [7:0]            mem_q [DEPTH];                       // [RQ13]

    always_comb
    begin
        rx_byte  = {sh_q[6:0], pin.si};
        addr_inc = addr_q + 1'b1;
        sr_view  = (sr_q & `SFSS_SR_WR_MASK) | {6'h0, wel_q, 1'b0};
    end

    // one process steps the whole serial protocol
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        op_d    = op_q;
        addr_d  = addr_q;
        tx_d    = tx_q;
        sr_d    = sr_q;
        wel_d   = wel_q;
        mode3_d = mode3_q;
        nab_d   = nab_q;
        wr_ok_d = wr_ok_q;
        so_d    = so_q;
        mem_we  = 1'b0;
        if (cs_fall)
        begin
            state_d = sfss_pkg::SFSS_ST_OPC;                    // [RQ17]
            cnt_d   = 3'h0;
            nab_d   = 1'b0;
            wr_ok_d = 1'b0;
            mode3_d = pin.sck;                                  // [RQ20] [RQ11]
        end
        else if (cs_rise)
        begin
            state_d = sfss_pkg::SFSS_ST_IDLE;                   // [RQ3]
            cnt_d   = 3'h0;
            if (wr_ok_q)
                wel_d = 1'b0;                                   // permission is one-shot
        end
        else if (sck_rise && state_q != sfss_pkg::SFSS_ST_IDLE &&
                 state_q != sfss_pkg::SFSS_ST_IGNORE)
        begin
            sh_d  = rx_byte;                                    // [RQ1]
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7)
            begin
                case (state_q)
                    sfss_pkg::SFSS_ST_OPC:
                    begin
                        op_d    = rx_byte;
                        state_d = sfss_pkg::SFSS_ST_IGNORE;     // [RQ19]
                        case (rx_byte)
                            `SFSS_OP_WREN: wel_d = 1'b1;
                            `SFSS_OP_WRDI: wel_d = 1'b0;        // [RQ15]
                            `SFSS_OP_RDSR:
                            begin
                                tx_d    = sr_view;
                                state_d = sfss_pkg::SFSS_ST_XFER;
                            end
                            `SFSS_OP_WRSR:
                                if (wel_q)
                                    state_d = sfss_pkg::SFSS_ST_XFER;  // [RQ15]
                            `SFSS_OP_READ: state_d = sfss_pkg::SFSS_ST_ADDR;
                            `SFSS_OP_WRITE:
                                if (wel_q)
                                    state_d = sfss_pkg::SFSS_ST_ADDR;  // [RQ15]
                            `SFSS_OP_RDID:
                            begin
                                tx_d    = id_byte(2'h0);        // [RQ16]
                                addr_d  = ADDR_W'(1);
                                state_d = sfss_pkg::SFSS_ST_XFER;
                            end
                            default: state_d = sfss_pkg::SFSS_ST_IGNORE;
                        endcase
                    end
                    sfss_pkg::SFSS_ST_ADDR:
                    begin
                        nab_d = 1'b1;
                        if (!nab_q)
                            addr_d[ADDR_W-1:8] = rx_byte[ADDR_W-9:0];  // [RQ18]
                        else
                        begin
                            addr_d[7:0] = rx_byte;
                            state_d     = sfss_pkg::SFSS_ST_XFER;
                            tx_d        = mem_q[{addr_q[ADDR_W-1:8], rx_byte}];
                        end
                    end
                    sfss_pkg::SFSS_ST_XFER:
                    begin
                        case (op_q)
                            `SFSS_OP_WRITE:
                            begin
                                mem_we  = ~is_protected(addr_q, sr_q[`SFSS_SR_BP_MSB:
                                                                   `SFSS_SR_BP_LSB]); // [RQ14]
                                addr_d  = addr_inc;
                                wr_ok_d = 1'b1;
                            end
                            `SFSS_OP_READ:
                            begin
                                addr_d = addr_inc;
                                tx_d   = mem_q[addr_inc];
                            end
                            `SFSS_OP_RDID:
                            begin
                                addr_d = addr_inc;
                                tx_d   = id_byte(addr_q[1:0]);  // [RQ16]
                            end
                            `SFSS_OP_WRSR:
                            begin
                                state_d = sfss_pkg::SFSS_ST_IGNORE;
                                if (pin.wp_n || !sr_q[`SFSS_SR_PEN_BIT])
                                begin
                                    sr_d    = rx_byte & `SFSS_SR_WR_MASK; // [RQ8]
                                    wr_ok_d = 1'b1;
                                end
                            end
                            default: tx_d = sr_view;            // status read repeats
                        endcase
                    end
                    default: state_d = sfss_pkg::SFSS_ST_IGNORE;
                endcase
            end
        end
        // next read bit goes out on the falling edge after the previous capture
        if (sck_fall && state_q == sfss_pkg::SFSS_ST_XFER && is_read_op(op_q))
            so_d = tx_q[~cnt_q];                                // [RQ6]
        so_oe_d = ~csn_d & pin.hold_n & is_read_op(op_q) &
                  (state_q == sfss_pkg::SFSS_ST_XFER);          // [RQ3] [RQ7]
    end

    // state holds through any clock pause since edges come from sys_clk sampling
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_q <= sfss_pkg::SFSS_ST_IDLE;
            cnt_q   <= 3'h0;
            sh_q    <= 8'h00;
            op_q    <= 8'h00;
            addr_q  <= '0;
            tx_q    <= 8'h00;
            sr_q    <= `SFSS_SR_RESET;
            wel_q   <= 1'b0;
            mode3_q <= 1'b0;
            nab_q   <= 1'b0;
            wr_ok_q <= 1'b0;
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
            sck_p_q <= 1'b0;
            csn_q   <= 1'b1;
        end
        else
        begin
            state_q <= state_d;                                 // [RQ2]
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            op_q    <= op_d;
            addr_q  <= addr_d;
            tx_q    <= tx_d;
            sr_q    <= sr_d;
            wel_q   <= wel_d;
            mode3_q <= mode3_d;
            nab_q   <= nab_d;
            wr_ok_q <= wr_ok_d;
            so_q    <= so_d;
            so_oe_q <= so_oe_d;
            sck_p_q <= pin.sck;
            csn_q   <= csn_d;
        end
    end

    // array has no reset: it models stored data, not control
    always_ff @(posedge sys_clk)
    begin
        if (mem_we)
            mem_q[addr_q] <= rx_byte;                           // [RQ12]
    end

    assign so_o  = so_q;
    assign so_oe = so_oe_q;

    // ****************************************
    // apb register slave, answers one cycle into the access phase
    // ****************************************
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;

    always_comb
    begin
        ctrl_en_d = ctrl_en_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        if (psel && penable && !pready_q)
        begin
            pready_d = 1'b1;
            prdata_d = 32'h0;
            case (paddr)
                `SFSS_REG_CTRL:
                begin
                    prdata_d[`SFSS_CTRL_EN_BIT] = ctrl_en_q;
                    if (pwrite && pstrb[0])
                        ctrl_en_d = pwdata[`SFSS_CTRL_EN_BIT];
                end
                `SFSS_REG_STATUS:
                begin
                    prdata_d[7:0]                       = sr_view;
                    prdata_d[`SFSS_STS_MODE]            = mode3_q;
                    prdata_d[`SFSS_STS_ST_LSB +: 3]     = state_q;
                    prdata_d[`SFSS_STS_SEL]             = ~csn_q;
                end
                `SFSS_REG_ADDR: prdata_d[ADDR_W-1:0] = addr_q;
                default: pslverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctrl_en_q <= `SFSS_CTRL_RESET;
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            ctrl_en_q <= ctrl_en_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cs_fall;
        cs_fall;
    endsequence

    sequence s_opc_wait;
        (state_q == sfss_pkg::SFSS_ST_OPC) && (cnt_q == 3'h0);
    endsequence

    a_sample_on_rise: assert property ($changed(sh_q) |-> $past(sck_rise)) // [RQ1]
        else $error("shift register moved without a rising serial clock");
    a_standby_hiz: assert property (csn_q |-> !so_oe_q) // [RQ3]
        else $error("serial output driven while deselected");
    a_gate_sck: assert property (csn_q && !cs_fall |=> $stable(cnt_q)) // [RQ4]
        else $error("bit counter moved while deselected");
    a_out_on_fall: assert property ($changed(so_q) |-> $past(sck_fall)) // [RQ6]
        else $error("serial output changed off a falling edge");
    a_hold_hiz: assert property (!$past(pin.hold_n) |-> !so_oe_q) // [RQ7]
        else $error("serial output driven during hold");
    a_status_lock: assert property (sck_rise && cnt_q == 3'h7 && !pin.wp_n && // [RQ8]
                                    sr_q[`SFSS_SR_PEN_BIT] |=> $stable(sr_q))
        else $error("status written while pin protection active");
    a_hold_freeze: assert property (!pin.hold_n |=> $stable(cnt_q) && // [RQ9]
                                    $stable(state_q) && $stable(csn_q))
        else $error("operation advanced during hold");
    a_commit_now: assert property (mem_we |=> mem_q[$past(addr_q)] == $past(rx_byte)) // [RQ12]
        else $error("byte not committed at its eighth bit");
    a_wrdi_clear: assert property (sck_rise && cnt_q == 3'h7 && // [RQ15]
                                   state_q == sfss_pkg::SFSS_ST_OPC &&
                                   rx_byte == `SFSS_OP_WRDI |=> !wel_q ##1 !wel_q)
        else $error("write permission survived write disable");
    a_opc_first: assert property (s_cs_fall |=> s_opc_wait) // [RQ17]
        else $error("select fall did not restart opcode capture");
    a_mode_pick: assert property (s_cs_fall |=> mode3_q == $past(pin.sck)) // [RQ20]
        else $error("mode not taken from clock level at select fall");

endmodule

// File: sfss_host_model.sv
`timescale 1ns/1ps

// ********
// spi host, half bit is four system clocks
// ********
module sfss_host_model
(
    input  wire logic sys_clk,
    input  wire logic so_pin,
    output logic      sck  = 1'b0,
    output logic      cs_n = 1'b1,
    output logic      si   = 1'b0
);
    logic mode3 = 1'b0;

    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // idle clock level picks the mode, fresh select fall per opcode
    task automatic sel(input logic m3);
        mode3 = m3;
        sck  <= m3;
        w(4);
        cs_n <= 1'b0;
        w(4);
    endtask

    // msb first; so read at the end of the low phase, just before the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck   <= 1'b0;
            si    <= tx[i];
            w(4);
            rx[i] = so_pin;
            sck   <= 1'b1;
            w(4);
        end
    endtask

    task automatic lo();
        sck <= 1'b0;
        w(4);
    endtask

    // clock stands still between frames, si left changed
    task automatic desel();
        sck  <= mode3;
        w(4);
        cs_n <= 1'b1;
        si   <= ~si;
        w(4);
    endtask
endmodule

// File: tb_serial_fram_spi_slave.sv
`timescale 1ns/1ps
`include "sfss_defs.svh"
`define CHK(x, y) begin check_count++; if ((x) !== (y)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, x, y); end end

module tb_serial_fram_spi_slave;
    localparam logic [31:0] ID = 32'h1b2e4d70; // arbitrary value
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        wp_n    = 1'b1;
    logic        hold_n  = 1'b1;
    int          oe_cnt  = 0;
    int          oe_ref;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'h0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, sck, cs_n, si, so_o, so_oe, so_pin, m3, e;
    logic [7:0]  b, d;
    logic [14:0] a;
    int          num_errors  = 0;
    int          check_count = 0;

    // ********
    // clock, pin, design and host
    // ********
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    assign so_pin = so_oe ? so_o : ~so_o; // released line keeps no stale level
    // counts every cycle the output is not plainly released, unknowns included
    always @(posedge sys_clk) if (so_oe !== 1'b0) oe_cnt <= oe_cnt + 1;

    sfss_spi_slave #(.DEVICE_ID(ID)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n),
        .si(si), .wp_n(wp_n), .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe));
    sfss_host_model u_host (.sys_clk(sys_clk), .so_pin(so_pin), .sck(sck), .cs_n(cs_n),
        .si(si));

    // apb master: request held until pready is seen high, giving up after 50 cycles
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= wd;
        pstrb   <= 4'hf;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) num_errors++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic cmd2(input logic [7:0] o, input logic [7:0] v);
        u_host.sel(m3);
        u_host.xfer(o, b);
        u_host.xfer(v, b);
        u_host.desel();
    endtask

    task automatic cmd(input logic [7:0] o);
        u_host.sel(m3);
        u_host.xfer(o, b);
        u_host.desel();
    endtask

    // writes send a set top address bit, which must be ignored
    task automatic mem(input logic [7:0] o, input logic [14:0] ad, input logic [7:0] v,
                       input logic en);
        if (en) cmd(`SFSS_OP_WREN);
        u_host.sel(m3);
        u_host.xfer(o, b);
        u_host.xfer({o == `SFSS_OP_WRITE, ad[14:8]}, b);
        cmd2(ad[7:0], v);
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #3ms;
        num_errors++;
        final_report();
    end

    initial
    begin
        void'($urandom(32'hf7cc));
        m3 = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, `SFSS_REG_STATUS, 32'h0);
        `CHK(r[12:0], 13'h0000)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({e, r}, 33'h1_0000_0000)
        // disabled block acts deselected
        apb(1'b1, `SFSS_REG_CTRL, 32'h0);
        cmd2(`SFSS_OP_RDSR, 8'h00);
        `CHK(oe_cnt, 0)
        apb(1'b1, `SFSS_REG_CTRL, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            m3 = i[0];
            a  = (i == 0) ? 15'h7fff : 15'($urandom);
            d  = 8'($urandom);
            mem(`SFSS_OP_WRITE, a, d, 1'b1);
            mem(`SFSS_OP_READ, a, 8'hff, 1'b0);
            `CHK(b, d)
        end
        cmd(`SFSS_OP_WREN);
        cmd(`SFSS_OP_WRDI);
        mem(`SFSS_OP_WRITE, a, ~d, 1'b0);
        mem(`SFSS_OP_READ, a, 8'hff, 1'b0);
        `CHK(b, d)
        oe_ref = oe_cnt;
        mem(8'h0b, a, 8'hff, 1'b0);
        `CHK(oe_cnt, oe_ref)
        // hold in mid-read: output released, clock pulses ignored
        u_host.sel(m3);
        u_host.xfer(`SFSS_OP_READ, b);
        u_host.xfer({1'b0, a[14:8]}, b);
        u_host.xfer(a[7:0], b);
        u_host.lo();
        hold_n <= 1'b0;
        repeat (2) u_host.xfer(8'h00, b);
        `CHK(so_oe, 1'b0)
        u_host.lo();
        hold_n <= 1'b1;
        u_host.w(6);
        // resume in the same selection; a new select step would add a clock rise
        u_host.xfer(8'hff, b);
        u_host.desel();
        `CHK(b, d)
        u_host.sel(1'b0);
        u_host.xfer(`SFSS_OP_RDID, b);
        for (int i = 0; i < 4; i++)
        begin
            u_host.xfer(8'h00, b);
            `CHK(b, ID[31-8*i -: 8])
        end
        u_host.desel();
        // top half protected: 4000 refused, 3fff still open
        mem(`SFSS_OP_WRITE, 15'h4000, 8'h3c, 1'b1);
        cmd(`SFSS_OP_WREN);
        cmd2(`SFSS_OP_WRSR, 8'h88);
        cmd2(`SFSS_OP_RDSR, 8'h00);
        `CHK(b, 8'h88)
        mem(`SFSS_OP_WRITE, 15'h4000, 8'hc3, 1'b1);
        mem(`SFSS_OP_READ, 15'h4000, 8'hff, 1'b0);
        `CHK(b, 8'h3c)
        mem(`SFSS_OP_WRITE, 15'h3fff, 8'h5e, 1'b1);
        mem(`SFSS_OP_READ, 15'h3fff, 8'hff, 1'b0);
        `CHK(b, 8'h5e)
        wp_n <= 1'b0;
        cmd(`SFSS_OP_WREN);
        cmd2(`SFSS_OP_WRSR, 8'h00);
        cmd2(`SFSS_OP_RDSR, 8'h00);
        `CHK(b, 8'h8a)
        final_report();
    end
endmodule
